// ==== hw/jac_pkg.sv ====
// constants, types and state codes for the jtag active-configuration control block
package jac_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int IR_W   = 4;
    localparam int BOOT_W = 22;
    localparam int ADDR_W = BOOT_W + 2;

    typedef logic [IR_W-1:0] jac_instr_t;

    // ------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------
    localparam jac_instr_t INS_DISENGAGE    = 4'h2;
    localparam jac_instr_t INS_ENGAGE       = 4'h3;
    localparam jac_instr_t INS_PULSE_RELOAD = 4'h4;
    localparam jac_instr_t INS_CLK_ENABLE   = 4'h5;
    localparam jac_instr_t INS_OSC_SELECT   = 4'h6;
    localparam jac_instr_t INS_BOOT_ADDR    = 4'h7;
    localparam jac_instr_t INS_STARTUP      = 4'h8;
    localparam jac_instr_t INS_PROGRAM      = 4'h9;
    localparam jac_instr_t INS_BYPASS       = 4'hf;
    localparam jac_instr_t IR_CAPTURE_VAL   = 4'h1;

    // ------------------------------------------------------------------
    // scheme select codes; every other code is a host-driven scheme
    // ------------------------------------------------------------------
    localparam logic [3:0] SCH_SERIAL_PROM  = 4'h2;
    localparam logic [3:0] SCH_PARALLEL_ROM = 4'h7;

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [BOOT_W-1:0] BOOT_UPD_RST     = 22'h00_0000;
    localparam logic [3:0]        USR_REVERT_EDGES = 4'ha;
    localparam logic [8:0]        PINS_RST         = 9'h00e;

    // ------------------------------------------------------------------
    // pin bundle, all asynchronous to core_clk
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] scheme;
        logic       tck;
        logic       tms;
        logic       tdi;
        logic       reload_n;
        logic       usr_clk;
    } jac_pins_t;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UP_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
    } jac_tap_t;

endpackage

// ==== hw/jac_ctrl.sv ====
// jtag-driven control of the self-loading configuration controllers
`timescale 1ns/100ps

//
// Behaviour
// (RULE1) disengage instruction idles the active self-loading controller
// (RULE2) serial scheme picks serial controller, parallel scheme picks parallel controller
// (RULE3) host issues disengage before jtag programming in self-loading schemes
// (RULE4) host-driven schemes ignore disengage; state stays unchanged
// (RULE5) host keeps instruction order: factory, disengage, program, status, startup, reset
// (RULE6) successful programming reaching user mode re-engages idle controllers
// (RULE7) serial scheme: tap reset or engage instruction re-engages serial controller
// (RULE8) parallel scheme: only engage instruction re-engages; reload pin never does
// (RULE9) engage instruction accepted anytime; re-engages and starts reconfiguration
// (RULE10) host-driven schemes: engage acts as pulse-reload instruction
// (RULE11) reload request pin disabled once engage instruction issued
// (RULE12) host keeps engage instruction as fail-safe only
// (RULE13) oscillator clocks controllers; clock-enable switches to user clock if oscillator runs
// (RULE14) oscillator stops in user mode unless reconfig, remote update or error detect
// (RULE15) user clock runs at twice config clock, at most 80 MHz
// (RULE16) host toggles user clock ten cycles after clock-disable instruction
// (RULE17) user-clock latch cleared only by clock-disable or power-on reset
// (RULE18) boot-address instruction places 22-bit shift register between tdi and tdo
// (RULE19) update register loaded from shift register; capture copies it back
// (RULE20) parallel boot address is register value with two zero bits appended
// (RULE21) with remote update the loaded boot address applies to factory image only
// (RULE22) boot address survives reconfiguration, lost at power-on reset
// (RULE23) power-on reset clears clock latch and restores default boot address
module jac_ctrl
    import jac_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    output logic                   tdo,
    output logic                   tdo_en,
    input  wire logic [3:0]        scheme_select_pins,
    input  wire logic              reload_request_n,
    input  wire logic              user_supplied_clock,
    input  wire logic              cfg_user_mode,
    input  wire logic              remote_update_en,
    input  wire logic              error_detect_en,
    input  wire logic              factory_image_sel,
    output logic                   serial_ctrl_idle,
    output logic                   parallel_ctrl_idle,
    output logic                   ctrl_user_mode_pulse,
    output logic                   reconfig_pulse,
    output logic                   reload_pin_disabled,
    output logic                   user_clk_selected,
    output logic                   osc_enable,
    output logic [ADDR_W-1:0]      par_boot_addr,
    output logic                   par_boot_addr_apply
);

    // ------------------------------------------------------------------
    // pin synchroniser: three stages, change taken when stages 2 and 3 agree
    // ------------------------------------------------------------------
    jac_pins_t pins_raw;
    jac_pins_t s1_q;
    jac_pins_t s2_q;
    jac_pins_t s3_q;
    jac_pins_t pin_q;
    jac_pins_t pin_d;

    assign pins_raw = '{scheme: scheme_select_pins, tck: tck, tms: tms, tdi: tdi,
                        reload_n: reload_request_n, usr_clk: user_supplied_clock};
    assign pin_d    = (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q  <= PINS_RST;
            s2_q  <= PINS_RST;
            s3_q  <= PINS_RST;
            pin_q <= PINS_RST;
        end else begin
            s1_q  <= pins_raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            pin_q <= pin_d;
        end
    end

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic tck_rise;
    logic tck_fall;
    logic usr_rise;
    logic reload_fall;
    logic um_rise;
    logic um_q;

    assign tck_rise    = pin_d.tck & ~pin_q.tck;
    assign tck_fall    = ~pin_d.tck & pin_q.tck;
    assign usr_rise    = pin_d.usr_clk & ~pin_q.usr_clk;
    assign reload_fall = ~pin_d.reload_n & pin_q.reload_n;
    assign um_rise     = cfg_user_mode & ~um_q;

    // ------------------------------------------------------------------
    // tap controller
    // ------------------------------------------------------------------
    jac_tap_t tap_q;
    jac_tap_t tap_nx;

    always_comb begin
        unique case (tap_q)
            TAP_RESET:  tap_nx = pin_q.tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tap_nx = pin_q.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_nx = pin_q.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_nx = pin_q.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_nx = pin_q.tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_nx = pin_q.tms ? TAP_UP_DR  : TAP_PA_DR;
            TAP_PA_DR:  tap_nx = pin_q.tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: tap_nx = pin_q.tms ? TAP_UP_DR  : TAP_SH_DR;
            TAP_UP_DR:  tap_nx = pin_q.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_nx = pin_q.tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: tap_nx = pin_q.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_nx = pin_q.tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_nx = pin_q.tms ? TAP_UP_IR  : TAP_PA_IR;
            TAP_PA_IR:  tap_nx = pin_q.tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: tap_nx = pin_q.tms ? TAP_UP_IR  : TAP_SH_IR;
            TAP_UP_IR:  tap_nx = pin_q.tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    jac_instr_t        ir_sh_q;
    jac_instr_t        instr_q;
    logic              byp_q;
    logic [BOOT_W-1:0] boot_sh_q;
    logic [BOOT_W-1:0] boot_upd_q;

    // decoded tap events, each one core_clk wide, and the boot_cur instruction decode level
    logic ir_update;
    logic tlr_entry;
    logic boot_cur;
    logic boot_cap;
    logic boot_shift;
    logic boot_update;

    assign ir_update   = tck_rise & (tap_q == TAP_UP_IR);
    assign tlr_entry   = tck_rise & (tap_q != TAP_RESET) & (tap_nx == TAP_RESET);
    assign boot_cur    = (instr_q == INS_BOOT_ADDR);
    assign boot_cap    = tck_rise & boot_cur & (tap_q == TAP_CAP_DR);
    assign boot_shift  = tck_rise & boot_cur & (tap_q == TAP_SH_DR);
    assign boot_update = tck_rise & boot_cur & (tap_q == TAP_UP_DR);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tap_q   <= TAP_RESET;
            ir_sh_q <= IR_CAPTURE_VAL;
            instr_q <= INS_BYPASS;
            byp_q   <= 1'b0;
        end else if (tck_rise) begin
            tap_q <= tap_nx;
            if (tap_q == TAP_RESET)
                instr_q <= INS_BYPASS;
            else if (tap_q == TAP_UP_IR)
                instr_q <= ir_sh_q;
            if (tap_q == TAP_CAP_IR)
                ir_sh_q <= IR_CAPTURE_VAL;
            else if (tap_q == TAP_SH_IR)
                ir_sh_q <= {pin_q.tdi, ir_sh_q[IR_W-1:1]};
            if (tap_q == TAP_SH_DR)
                byp_q <= pin_q.tdi;
            else if (tap_q == TAP_CAP_DR)
                byp_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // boot-address registers, cleared only by power-on reset
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_sh_q  <= BOOT_UPD_RST;
            boot_upd_q <= BOOT_UPD_RST;                                   // RULE23
        end else begin
            if (boot_cap)
                boot_sh_q <= boot_upd_q;                                  // RULE19
            else if (boot_shift)
                boot_sh_q <= {pin_q.tdi, boot_sh_q[BOOT_W-1:1]};          // RULE18
            if (boot_update)
                boot_upd_q <= boot_sh_q;                                  // RULE19 RULE22
        end
    end

    // tdo changes on the falling tck edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdo    <= 1'b0;
            tdo_en <= 1'b0;
        end else if (tck_fall) begin
            tdo_en <= (tap_q == TAP_SH_DR) | (tap_q == TAP_SH_IR);
            if (tap_q == TAP_SH_IR)
                tdo <= ir_sh_q[0];
            else
                tdo <= boot_cur ? boot_sh_q[0] : byp_q;                   // RULE18
        end
    end

    // ------------------------------------------------------------------
    // controller engage / disengage
    // ------------------------------------------------------------------
    logic is_serial;
    logic is_parallel;
    logic is_host;
    logic ev_disengage;
    logic ev_engage;
    logic ev_pulse;
    logic ev_clk_en;
    logic ev_clk_dis;
    logic any_idle;
    logic pin_reload;

    assign is_serial    = (pin_q.scheme == SCH_SERIAL_PROM);              // RULE2
    assign is_parallel  = (pin_q.scheme == SCH_PARALLEL_ROM);             // RULE2
    assign is_host      = ~is_serial & ~is_parallel;
    assign ev_disengage = ir_update & (ir_sh_q == INS_DISENGAGE);
    assign ev_engage    = ir_update & (ir_sh_q == INS_ENGAGE);
    assign ev_pulse     = ir_update & (ir_sh_q == INS_PULSE_RELOAD);
    assign ev_clk_en    = ir_update & (ir_sh_q == INS_CLK_ENABLE);
    assign ev_clk_dis   = ir_update & (ir_sh_q == INS_OSC_SELECT);
    assign any_idle     = serial_ctrl_idle | parallel_ctrl_idle;
    assign pin_reload   = reload_fall & ~reload_pin_disabled;             // RULE11

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_ctrl_idle     <= 1'b0;
            parallel_ctrl_idle   <= 1'b0;
            ctrl_user_mode_pulse <= 1'b0;
            reconfig_pulse       <= 1'b0;
            reload_pin_disabled  <= 1'b0;
            um_q                 <= 1'b0;
        end else begin
            um_q                 <= cfg_user_mode;
            ctrl_user_mode_pulse <= um_rise & any_idle;                   // RULE6
            // reload pin reconfigures and, while low, sets osc_hold_q; it never touches the idle flags
            reconfig_pulse       <= ev_engage | ev_pulse | pin_reload;    // RULE8 RULE9 RULE10
            if (ev_engage)
                reload_pin_disabled <= 1'b1;                              // RULE11
            if (ev_engage | um_rise) begin
                serial_ctrl_idle   <= 1'b0;                               // RULE6 RULE9
                parallel_ctrl_idle <= 1'b0;
            end else if (ev_disengage & ~is_host) begin                   // RULE4
                serial_ctrl_idle   <= serial_ctrl_idle | is_serial;       // RULE1
                parallel_ctrl_idle <= parallel_ctrl_idle | is_parallel;   // RULE1
            end else if (tlr_entry & is_serial) begin
                serial_ctrl_idle   <= 1'b0;                               // RULE7
            end
        end
    end

    // ------------------------------------------------------------------
    // controller clock source and oscillator
    // ------------------------------------------------------------------
    logic       revert_pend_q;
    logic [3:0] revert_cnt_q;
    logic       osc_hold_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            user_clk_selected <= 1'b0;                                    // RULE23
            revert_pend_q     <= 1'b0;
            revert_cnt_q      <= 4'h0;
        end else if (ev_clk_dis) begin
            revert_pend_q <= user_clk_selected;
            revert_cnt_q  <= 4'h0;
        end else if (revert_pend_q) begin
            // source switches back only after the user clock has run on
            if (usr_rise & (revert_cnt_q == USR_REVERT_EDGES - 4'h1)) begin
                user_clk_selected <= 1'b0;                                // RULE17
                revert_pend_q     <= 1'b0;
            end else if (usr_rise) begin
                revert_cnt_q <= revert_cnt_q + 4'h1;
            end
        end else if (ev_clk_en & osc_enable) begin
            user_clk_selected <= 1'b1;                                    // RULE13
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_hold_q <= 1'b0;
            osc_enable <= 1'b1;                                           // RULE13
        end else begin
            if (reconfig_pulse | ~pin_q.reload_n)
                osc_hold_q <= 1'b1;
            else if (um_rise)
                osc_hold_q <= 1'b0;
            osc_enable <= ~cfg_user_mode | osc_hold_q
                        | remote_update_en | error_detect_en;             // RULE14
        end
    end

    // ------------------------------------------------------------------
    // boot address to the parallel controller
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            par_boot_addr       <= {BOOT_UPD_RST, 2'b00};
            par_boot_addr_apply <= 1'b0;
        end else begin
            par_boot_addr       <= {boot_upd_q, 2'b00};                   // RULE20
            par_boot_addr_apply <= ~remote_update_en | factory_image_sel; // RULE21
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence seq_boot_load;
        (boot_upd_q == $past(boot_sh_q)) ##1 (par_boot_addr == {$past(boot_upd_q), 2'b00});
    endsequence

    sequence seq_engage_done;
        reconfig_pulse && reload_pin_disabled && !serial_ctrl_idle && !parallel_ctrl_idle;
    endsequence

    AST_DISENGAGE_ACTIVE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE1
        ev_disengage && !ev_engage && !um_rise && !is_host
        |=> (serial_ctrl_idle == $past(is_serial | serial_ctrl_idle))
            && (parallel_ctrl_idle == $past(is_parallel | parallel_ctrl_idle)))
        else $error("disengage did not idle the active controller");

    AST_HOST_IGNORES: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE4
        ev_disengage && is_host && !um_rise
        |=> $stable(serial_ctrl_idle) && $stable(parallel_ctrl_idle))
        else $error("disengage changed state in a host-driven scheme");

    AST_SUCCESS_REENGAGE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE6
        um_rise && any_idle
        |=> ctrl_user_mode_pulse && !serial_ctrl_idle && !parallel_ctrl_idle ##1 !ctrl_user_mode_pulse)
        else $error("user mode entry did not re-engage controllers");

    AST_TAP_RESET_SERIAL: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE7
        tlr_entry && is_serial |=> !serial_ctrl_idle)
        else $error("tap reset did not re-engage serial controller");

    AST_PIN_NO_ENGAGE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE8
        reload_fall && parallel_ctrl_idle && !ev_engage && !um_rise |=> parallel_ctrl_idle)
        else $error("reload pin re-engaged the parallel controller");

    AST_ENGAGE: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE9
        ev_engage |=> seq_engage_done ##1 !reconfig_pulse [*2])
        else $error("engage instruction did not re-engage and reconfigure");

    AST_PIN_DISABLED: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE11
        reload_fall && reload_pin_disabled && !ev_engage && !ev_pulse |=> !reconfig_pulse)
        else $error("reload pin acted after engage instruction");

    AST_CLK_NEEDS_OSC: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE13
        ev_clk_en && !osc_enable && !user_clk_selected |=> !user_clk_selected)
        else $error("user clock selected with oscillator stopped");

    AST_CLK_LATCH_HOLDS: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE17
        user_clk_selected && !revert_pend_q && !ev_clk_dis |=> user_clk_selected)
        else $error("user clock latch cleared without clock-disable");

    AST_OSC_STOP: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE14
        cfg_user_mode && !osc_hold_q && !remote_update_en && !error_detect_en |=> !osc_enable)
        else $error("oscillator kept running in plain user mode");

    AST_BOOT_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst) // RULE19
        boot_update |=> seq_boot_load)
        else $error("boot address not passed on with two zero bits");

endmodule

// ==== dv/jac_host.sv ====
// jtag host model for the test access port and the user clock pin
`timescale 1ns/100ps
module jac_host
    import jac_pkg::*;
(
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      usr_clk,
    input  wire logic tdo
);
    logic tdo_s;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        usr_clk = 1'b0;
    end
    // one tck period, tms and tdi set up half a period before the rise
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #62.5 tck = 1'b1;
        tdo_s = tdo;
        #62.5 tck = 1'b0;
    endtask
    // five tms-high periods reach the reset state, then park in idle
    task automatic tap_reset();
        repeat (5) step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic load_ir(input jac_instr_t code);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < IR_W; i++) begin
            step(i == IR_W - 1, code[i]);
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
    endtask
    task automatic shift_dr(input logic [BOOT_W-1:0] din, output logic [BOOT_W-1:0] dout);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
        step(1'b0, 1'b0);
        for (int i = 0; i < BOOT_W; i++) begin
            step(i == BOOT_W - 1, din[i]);
            dout[i] = tdo_s;
        end
        step(1'b1, 1'b0);
        step(1'b0, 1'b1);
    endtask
    // 10 MHz user clock, well under the 80 MHz ceiling
    task automatic usr_edges(input int n);
        repeat (n) begin
            #50 usr_clk = 1'b1;
            #50 usr_clk = 1'b0;
        end
    endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the jtag active-configuration control block
`timescale 1ns/100ps
module tb
    import jac_pkg::*;
;
    logic core_clk = 1'b0, sys_rst = 1'b1, tck, tms, tdi, tdo, usr_clk, reload_n = 1'b1;
    logic cfg_um = 1'b0, rem = 1'b0, err = 1'b0, fac = 1'b0, s_idle, p_idle, um_p, rc_p, rl_dis;
    logic ucs, osc, apply, ten;
    logic [3:0] scheme = 4'h0;
    logic [ADDR_W-1:0] pba, n_rcfg = '0, n_um = '0, n_en = '0, n0;
    logic [BOOT_W-1:0] dout;
    int n_mismatch = 0, checks = 0;
    localparam logic [BOOT_W-1:0] V = 22'h2a_5c31;
    jac_ctrl uut (.core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_en(ten), .scheme_select_pins(scheme), .reload_request_n(reload_n),
        .user_supplied_clock(usr_clk), .cfg_user_mode(cfg_um), .remote_update_en(rem),
        .error_detect_en(err), .factory_image_sel(fac), .serial_ctrl_idle(s_idle),
        .parallel_ctrl_idle(p_idle), .ctrl_user_mode_pulse(um_p), .reconfig_pulse(rc_p),
        .reload_pin_disabled(rl_dis), .user_clk_selected(ucs), .osc_enable(osc),
        .par_boot_addr(pba), .par_boot_addr_apply(apply));
    jac_host host (.tck(tck), .tms(tms), .tdi(tdi), .usr_clk(usr_clk), .tdo(tdo));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_rcfg <= n_rcfg + (rc_p === 1'b1);
        n_um <= n_um + (um_p === 1'b1);
        n_en <= n_en + (ten === 1'b1);
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic check(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse_reload();
        reload_n = 1'b0;
        cyc(10);
        reload_n = 1'b1;
        cyc(10);
    endtask
    task automatic t_serial();
        scheme = SCH_SERIAL_PROM;
        cyc(8);
        host.load_ir(INS_DISENGAGE);
        check(s_idle, 1);
        check(p_idle, 0);
        host.load_ir(INS_PROGRAM);
        host.load_ir(INS_STARTUP);
        check(s_idle, 1);
        host.tap_reset();
        check(s_idle, 0);
    endtask
    task automatic t_parallel();
        scheme = SCH_PARALLEL_ROM;
        cyc(8);
        host.load_ir(INS_DISENGAGE);
        check(p_idle, 1);
        host.tap_reset();
        check(p_idle, 1);
        n0 = n_rcfg;
        pulse_reload();
        check(n_rcfg - n0, 1);
        check(p_idle, 1);
        cfg_um = 1'b1;
        cyc(3);
        check(p_idle, 0);
        check(n_um, 1);
        check(osc, 0);
        rem = 1'b1;
        cyc(3);
        check(osc, 1);
        rem = 1'b0;
        cyc(3);
        host.load_ir(INS_CLK_ENABLE);
        check(ucs, 0);
        cfg_um = 1'b0;
        cyc(3);
    endtask
    task automatic t_clock();
        host.load_ir(INS_CLK_ENABLE);
        check(ucs, 1);
        host.tap_reset();
        pulse_reload();
        check(ucs, 1);
        host.load_ir(INS_OSC_SELECT);
        host.usr_edges(9);
        cyc(10);
        check(ucs, 1);
        host.usr_edges(1);
        cyc(10);
        check(ucs, 0);
    endtask
    task automatic t_host();
        scheme = 4'h0;
        cyc(8);
        host.load_ir(INS_DISENGAGE);
        check({s_idle, p_idle}, 0);
        n0 = n_rcfg;
        host.load_ir(INS_ENGAGE);
        check(n_rcfg - n0, 1);
        check(rl_dis, 1);
        pulse_reload();
        check(n_rcfg - n0, 1);
    endtask
    task automatic t_boot();
        scheme = SCH_PARALLEL_ROM;
        cyc(8);
        host.load_ir(INS_BOOT_ADDR);
        n0 = n_en;
        host.shift_dr(V, dout);
        check(dout, 0);
        // output enable stands for 22 tck periods of 12.5 core_clk each
        check(n_en - n0, BOOT_W * 125 / 10);
        check(pba, {V, 2'b00});
        host.shift_dr(V, dout);
        check(dout, V);
        check(apply, 1);
        rem = 1'b1;
        cyc(3);
        check(apply, 0);
        fac = 1'b1;
        cyc(3);
        check(apply, 1);
        rem = 1'b0;
        host.load_ir(INS_DISENGAGE);
        host.load_ir(INS_ENGAGE);
        check(p_idle, 0);
        check(pba, {V, 2'b00});
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(2);
        check(pba, 0);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end
    initial begin
        cyc(2);
        sys_rst = 1'b0;
        cyc(6);
        check(osc, 1);
        check(ucs, 0);
        check(pba, 0);
        check(ten, 0);
        host.tap_reset();
        t_serial();
        t_parallel();
        t_clock();
        t_host();
        t_boot();
        close_out();
    end
endmodule
